/* core/prtc_defs.vh */
`ifndef PRTC_DEFS_VH
`define PRTC_DEFS_VH
// Register indices (printed offsets are not word multiples); byte address = 4 * index
`define PRTC_IDX_CTRL      12'h600
`define PRTC_IDX_NS_LO     12'h604
`define PRTC_IDX_NS_HI     12'h606
`define PRTC_IDX_SEC_LO    12'h608
`define PRTC_IDX_SEC_HI    12'h60a
`define PRTC_IDX_PHASE     12'h60c
`define PRTC_IDX_RATE_LO   12'h610
`define PRTC_IDX_RATE_HI   12'h612
`define PRTC_IDX_STATUS    12'h618
// Control word fields
`define PRTC_CTL_STEP      6
`define PRTC_CTL_STEP_DIR  5
`define PRTC_CTL_SAMPLE    4
`define PRTC_CTL_LOAD      3
`define PRTC_CTL_CONT      2
`define PRTC_CTL_RUN       1
`define PRTC_CTL_CLEAR     0
// Rate high word fields
`define PRTC_RATE_DIR      15
`define PRTC_RATE_TEMP     14
// Reset values
`define PRTC_RST_WORD      16'h0000
`define PRTC_RST_RUN       1'b1
// Timing
`define PRTC_CLK_MHZ       25
`define PRTC_TICK_NS       40
`define PRTC_PHASE_NS      8
`define PRTC_PHASE_STEPS   (`PRTC_TICK_NS / `PRTC_PHASE_NS)
`define PRTC_NS_PER_SEC    30'd1000000000
`endif

/* core/prtc_time_store.v */
`timescale 1ns/1ps
`include "prtc_defs.vh"
// Host-visible time words, 4 x 16 bits, with registered read data
module prtc_time_store (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    // Write port
    input  wire        wr_en,
    input  wire [1:0]  wr_addr,
    input  wire [15:0] wr_data,
    // Bulk load of all words from the running clock
    input  wire        bulk_en,
    input  wire [63:0] bulk_data,
    // Read port
    input  wire [1:0]  rd_addr,
    output reg  [15:0] rd_data,
    // Whole content
    output wire [63:0] all_data
);
    reg [15:0] word_mem [0:3];
    integer i;

    assign all_data = {word_mem[3], word_mem[2], word_mem[1], word_mem[0]};

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 4; i = i + 1) begin
                word_mem[i] <= `PRTC_RST_WORD;
            end
            rd_data <= `PRTC_RST_WORD;
        end else begin
            if (bulk_en) begin
                word_mem[0] <= bulk_data[15:0];
                word_mem[1] <= bulk_data[31:16];
                word_mem[2] <= bulk_data[47:32];
                word_mem[3] <= bulk_data[63:48];
            end else if (wr_en) begin
                word_mem[wr_addr] <= wr_data;
            end
            rd_data <= word_mem[rd_addr];
        end
    end
endmodule

/* core/prtc_rtc.v */
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "prtc_defs.vh"
module prtc_rtc #(
    parameter ADDR_W = 14
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Temporary adjust done, from the duration counter outside
    input  wire        temp_adjust_done,
    // Running time
    output reg  [31:0] rtc_seconds,
    output reg  [29:0] rtc_nanoseconds,
    output reg  [2:0]  rtc_sub_phase,
    output reg         rtc_temp_adjust
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_RDWAIT = 2'd1;
    localparam [1:0] ST_RDOUT = 2'd2;

    // Address phase capture
    reg              dp_write;
    reg              dp_read;
    reg [11:0]       dp_idx;
    reg [1:0]        state;

    // Control and rate state
    reg              run_enable;
    reg              cont_adjust;
    reg              step_dir;
    reg              rate_dir;
    reg [29:0]       rate_value;
    reg [31:0]       frac_acc;
    reg              load_pend;
    reg              sample_pend;
    reg              step_pend;
    reg [2:0]        phase_word;
    reg [15:0]       rd_mux;

    wire [63:0]      words;
    wire [15:0]      store_rd;
    wire             store_wr;
    wire [1:0]       store_addr;
    wire             addr_phase;
    wire             is_time_word;
    wire             ctl_wr;
    wire             rate_nonzero;
    wire             adjusting;
    wire [32:0]      frac_sum;
    wire [29:0]      tick_ns;
    wire [29:0]      step_ns;
    wire [61:0]      tick_time;
    wire [61:0]      base_time;
    wire             temp_start;

    function is_time_idx;
        input [11:0] idx;
        begin
            is_time_idx = (idx == `PRTC_IDX_NS_LO) || (idx == `PRTC_IDX_NS_HI) ||
                          (idx == `PRTC_IDX_SEC_LO) || (idx == `PRTC_IDX_SEC_HI);
        end
    endfunction

    // Adds a signed nanosecond delta below one second, wrapping seconds
    function [61:0] ns_add;
        input [31:0] sec;
        input [29:0] ns;
        input [29:0] delta;
        input        sub;
        reg   [30:0] t;
        begin
            if (sub) begin
                if (ns >= delta) begin
                    ns_add = {sec, ns - delta};
                end else begin
                    t = {1'b0, ns} + {1'b0, `PRTC_NS_PER_SEC} - {1'b0, delta};
                    ns_add = {sec - 32'd1, t[29:0]};
                end
            end else begin
                t = {1'b0, ns} + {1'b0, delta};
                if (t >= {1'b0, `PRTC_NS_PER_SEC}) begin
                    t = t - {1'b0, `PRTC_NS_PER_SEC};
                    ns_add = {sec + 32'd1, t[29:0]};
                end else begin
                    ns_add = {sec, t[29:0]};
                end
            end
        end
    endfunction

    assign addr_phase = hsel && hready && htrans[1];
    assign is_time_word = is_time_idx(dp_idx);
    assign store_wr = dp_write && is_time_word;
    assign store_addr = dp_idx[2:1] - 2'd2;
    assign ctl_wr = dp_write && (dp_idx == `PRTC_IDX_CTRL);

    prtc_time_store u_store (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .wr_en     (store_wr),
        .wr_addr   (store_addr),
        .wr_data   (hwdata[15:0]),
        .bulk_en   (sample_pend),
        .bulk_data ({rtc_seconds, 2'b00, rtc_nanoseconds[29:16],
                     rtc_nanoseconds[15:0]}),
        .rd_addr   (store_addr),
        .rd_data   (store_rd),
        .all_data  (words)
    );

    // Adjust is off whenever the rate is zero
    assign rate_nonzero = (rate_value != 30'd0);
    assign adjusting = rate_nonzero && (cont_adjust || rtc_temp_adjust);
    // Fraction accumulates in 2^-32 ns units; carry gives whole ns
    assign frac_sum = rate_dir ? {1'b0, frac_acc} - {3'b000, rate_value}
                               : {1'b0, frac_acc} + {3'b000, rate_value};
    assign tick_ns = rate_dir ? (frac_sum[32] ? 30'd39 : 30'd40)
                              : (frac_sum[32] ? 30'd41 : 30'd40);
    assign step_ns = {words[29:16], words[15:0]};
    // A step rides on the tick of its cycle, so no 40 ns is lost
    assign tick_time = ns_add(rtc_seconds, rtc_nanoseconds,
                              adjusting ? tick_ns : 30'd40, 1'b0);
    assign base_time = run_enable ? tick_time : {rtc_seconds, rtc_nanoseconds};
    assign temp_start = dp_write && (dp_idx == `PRTC_IDX_RATE_HI) &&
                        hwdata[`PRTC_RATE_TEMP] &&
                        ({hwdata[13:0], rate_value[15:0]} != 30'd0);

    // Bus slave
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_idx <= 12'h000;
            state <= ST_IDLE;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (addr_phase) begin
                        dp_idx <= haddr[13:2];
                        dp_write <= hwrite;
                        dp_read <= !hwrite;
                        if (!hwrite) begin
                            state <= ST_RDWAIT;
                            hreadyout <= 1'b0;
                        end
                    end
                end
                ST_RDWAIT: begin
                    state <= ST_RDOUT;
                end
                default: begin
                    hrdata <= {16'h0000, rd_mux};
                    hreadyout <= 1'b1;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data select, one cycle after store read
    always @* begin
        if (is_time_word) begin
            rd_mux = store_rd;
        end else if (dp_idx == `PRTC_IDX_CTRL) begin
            rd_mux = {13'h0000, cont_adjust, run_enable, 1'b0};
            rd_mux[`PRTC_CTL_STEP_DIR] = step_dir;
        end else if (dp_idx == `PRTC_IDX_PHASE) begin
            rd_mux = {13'h0000, phase_word};
        end else if (dp_idx == `PRTC_IDX_RATE_LO) begin
            rd_mux = rate_value[15:0];
        end else if (dp_idx == `PRTC_IDX_RATE_HI) begin
            rd_mux = {rate_dir, rtc_temp_adjust, rate_value[29:16]};
        end else if (dp_idx == `PRTC_IDX_STATUS) begin
            rd_mux = {15'h0000, adjusting};
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Store read address is the latched data-phase index
    // Control, rate and command registers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_enable <= `PRTC_RST_RUN;
            cont_adjust <= 1'b0;
            step_dir <= 1'b0;
            rate_dir <= 1'b0;
            rate_value <= 30'd0;
            rtc_temp_adjust <= 1'b0;
            load_pend <= 1'b0;
            sample_pend <= 1'b0;
            step_pend <= 1'b0;
            phase_word <= 3'd0;
        end else begin
            load_pend <= 1'b0;
            sample_pend <= 1'b0;
            step_pend <= 1'b0;
            if (ctl_wr) begin
                run_enable <= hwdata[`PRTC_CTL_RUN];
                cont_adjust <= hwdata[`PRTC_CTL_CONT];
                step_dir <= hwdata[`PRTC_CTL_STEP_DIR];
                load_pend <= hwdata[`PRTC_CTL_LOAD];
                sample_pend <= hwdata[`PRTC_CTL_SAMPLE];
                step_pend <= hwdata[`PRTC_CTL_STEP];
            end
            if (dp_write && dp_idx == `PRTC_IDX_RATE_LO) begin
                rate_value[15:0] <= hwdata[15:0];
            end
            if (dp_write && dp_idx == `PRTC_IDX_RATE_HI) begin
                rate_value[29:16] <= hwdata[13:0];
                rate_dir <= hwdata[`PRTC_RATE_DIR];
            end
            // Start wins over done; a zero rate never starts and stops a run
            if (temp_start) begin
                rtc_temp_adjust <= 1'b1;
            end else if (temp_adjust_done || !rate_nonzero) begin
                rtc_temp_adjust <= 1'b0;
            end
            if (store_wr) begin
                phase_word <= 3'd0;
            end else if (dp_write && dp_idx == `PRTC_IDX_PHASE) begin
                phase_word <= hwdata[2:0];
            end else if (sample_pend) begin
                phase_word <= rtc_sub_phase;
            end
        end
    end

    // Running clock
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rtc_seconds <= 32'd0;
            rtc_nanoseconds <= 30'd0;
            rtc_sub_phase <= 3'd0;
            frac_acc <= 32'd0;
        end else if (load_pend) begin
            rtc_seconds <= words[63:32];
            rtc_nanoseconds <= step_ns;
            rtc_sub_phase <= phase_word;
        end else begin
            if (run_enable) begin
                // Phase is only a label; mclk is the 40 ns tick itself
                rtc_sub_phase <= 3'd0;
                if (adjusting) begin
                    frac_acc <= frac_sum[31:0];
                end
            end
            if (step_pend) begin
                {rtc_seconds, rtc_nanoseconds} <= ns_add(base_time[61:30], base_time[29:0],
                                                         step_ns, !step_dir);
            end else begin
                {rtc_seconds, rtc_nanoseconds} <= base_time;
            end
        end
    end
endmodule

/* bench/prtc_rtc_props.sv */
`timescale 1ns/1ps
module prtc_rtc_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Time
    input wire logic        temp_adjust_done,
    input wire logic [31:0] rtc_seconds,
    input wire logic [29:0] rtc_nanoseconds,
    input wire logic [2:0]  rtc_sub_phase,
    input wire logic        rtc_temp_adjust
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [2:0]  since_wr;
    wire         take = hsel && hready && htrans[1];
    wire         wr_take = take && hwrite;
    wire [11:0]  idx = haddr[13:2];
    wire         rd_phase = take && !hwrite && idx == 12'h60c;
    wire         time_wr = wr_take && idx[11:4] == 8'h60 && idx[3:1] inside {3'd2, 3'd3, 3'd4, 3'd5};
    // Host writes may move the time; only judge counting well clear of them
    wire         quiet = since_wr == 3'd7;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            since_wr <= 3'd0;
        else if (wr_take)
            since_wr <= 3'd0;
        else if (since_wr != 3'd7)
            since_wr <= since_wr + 3'd1;
    end
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
    a_write_no_wait: assert property (wr_take |=> hreadyout) else $error("write stalled");
    a_read_two_wait: assert property (take && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_ns_below_wrap: assert property (rtc_nanoseconds < 30'd1000000000) else $error("ns over");
    a_phase_legal: assert property (rtc_sub_phase <= 3'd4) else $error("bad phase");
    a_phase_clear: assert property (time_wr ##1 (!take)[*2] ##1 rd_phase |->
        ##3 hrdata[2:0] == 3'd0) else $error("phase kept");
    a_tick_step: assert property (quiet && $past(rtc_nanoseconds) < 30'd999999000 |->
        rtc_nanoseconds - $past(rtc_nanoseconds) inside {30'd0, 30'd39, 30'd40, 30'd41})
        else $error("bad tick step");
    a_sec_carry: assert property (quiet && $past(rtc_nanoseconds) > rtc_nanoseconds |->
        rtc_seconds == $past(rtc_seconds) + 32'd1) else $error("no carry");
    a_sec_steady: assert property (quiet && $past(rtc_nanoseconds) <= rtc_nanoseconds |->
        $stable(rtc_seconds)) else $error("seconds moved");
    c_read: cover property (take && !hwrite);
    c_ctrl: cover property (wr_take && idx == 12'h600);
    c_carry: cover property (quiet && $past(rtc_nanoseconds) > rtc_nanoseconds);
endmodule

bind prtc_rtc prtc_rtc_props u_props (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .temp_adjust_done(temp_adjust_done),
    .rtc_seconds(rtc_seconds), .rtc_nanoseconds(rtc_nanoseconds),
    .rtc_sub_phase(rtc_sub_phase), .rtc_temp_adjust(rtc_temp_adjust));

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "prtc_defs.vh"
module tb_top;
    logic        mclk;
    logic        rst_b;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        temp_adjust_done;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] rtc_seconds;
    wire  [29:0] rtc_nanoseconds;
    wire  [2:0]  rtc_sub_phase;
    wire         rtc_temp_adjust;
    int          errors;
    int          checks_done;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [31:0] t0;
    logic [31:0] v;

    prtc_rtc dut (.mclk(mclk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .temp_adjust_done(temp_adjust_done),
        .rtc_seconds(rtc_seconds), .rtc_nanoseconds(rtc_nanoseconds),
        .rtc_sub_phase(rtc_sub_phase), .rtc_temp_adjust(rtc_temp_adjust));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Lowest legal advance over n ticks; the fraction carried in leaves one ns of slack
    function [31:0] adv(input int n, input [29:0] r, input dn);
        adv = dn ? n * 40 - ((n * 64'(r)) >> 32) - 1 : n * 40 + ((n * 64'(r)) >> 32);
    endfunction

    task chk(input string what, input [31:0] exp, input [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task bus(input [11:0] idx, input w, input [31:0] d);
        @(posedge mclk);
        htrans <= 2'b10;
        haddr <= {18'h0, idx, 2'b00};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rd_chk(input string what, input [11:0] idx, input [15:0] exp);
        bus(idx, 1'b0, 32'h0);
        chk(what, {16'h0, exp}, {16'h0, rd[15:0]});
    endtask

    task ticks(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #800000;
        errors++;
        end_sim();
    end

    initial begin
        rst_b = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        temp_adjust_done = 1'b0;
        errors = 0;
        checks_done = 0;
        seed = 32'h20cec212;
        ticks(6);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk("reset", 12'h604 + 12'(2 * i), 16'h0000);
        bus(12'h602, 1'b1, 32'hffff);
        rd_chk("unmapped", 12'h602, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bus(12'h604 + 12'(2 * (i % 4)), 1'b1, seed);
            rd_chk("word", 12'h604 + 12'(2 * (i % 4)), seed[15:0]);
        end
        bus(`PRTC_IDX_PHASE, 1'b1, 32'h3);
        rd_chk("phase", `PRTC_IDX_PHASE, 16'h0003);
        bus(`PRTC_IDX_SEC_HI, 1'b1, 32'h1234);
        rd_chk("phase_clr", `PRTC_IDX_PHASE, 16'h0000);
        // Load 200 ns short of a second, low seconds word full so the carry crosses words
        bus(`PRTC_IDX_NS_LO, 1'b1, 32'hc938);
        bus(`PRTC_IDX_NS_HI, 1'b1, 32'h3b9a);
        bus(`PRTC_IDX_SEC_LO, 1'b1, 32'hffff);
        bus(`PRTC_IDX_CTRL, 1'b1, 32'h000a);
        ticks(3);
        chk("load_sec", 32'h1234ffff, rtc_seconds);
        ticks(10);
        chk("carry_sec", 32'h12350000, rtc_seconds);
        chk("carry_ns", 32'h1, {31'h0, rtc_nanoseconds < 30'd400});
        for (int k = 0; k < 3; k++) begin
            bus(`PRTC_IDX_RATE_LO, 1'b1, k == 0 ? 32'h0 : 32'hffff);
            bus(`PRTC_IDX_RATE_HI, 1'b1, k == 0 ? 32'h0 : (k == 2 ? 32'hbfff : 32'h3fff));
            bus(`PRTC_IDX_CTRL, 1'b1, 32'h0006);
            ticks(4);
            t0 = rtc_nanoseconds;
            ticks(100);
            v = {2'b00, rtc_nanoseconds} - t0 - adv(100, k == 0 ? 30'h0 : 30'h3fffffff, k == 2);
            chk("rate_adv", 32'h1, {31'h0, v <= (k != 0)});
        end
        bus(`PRTC_IDX_RATE_LO, 1'b1, 32'h0);
        bus(`PRTC_IDX_RATE_HI, 1'b1, 32'h0);
        seed = lfsr(seed);
        for (int k = 0; k < 2; k++) begin
            bus(`PRTC_IDX_NS_LO, 1'b1, {16'h0, seed[15:0]});
            bus(`PRTC_IDX_NS_HI, 1'b1, 32'h0);
            ticks(2);
            t0 = rtc_nanoseconds;
            bus(`PRTC_IDX_CTRL, 1'b1, k == 0 ? 32'h0062 : 32'h0042);
            ticks(20);
            v = k == 0 ? t0 + 920 + seed[15:0] : t0 + 920 - seed[15:0];
            chk("step", v, {2'b00, rtc_nanoseconds});
        end
        bus(`PRTC_IDX_CTRL, 1'b1, 32'h0000);
        ticks(3);
        t0 = rtc_nanoseconds;
        ticks(10);
        chk("frozen", t0, {2'b00, rtc_nanoseconds});
        bus(`PRTC_IDX_NS_LO, 1'b1, 32'h5a5a);
        bus(`PRTC_IDX_NS_HI, 1'b1, 32'h0001);
        bus(`PRTC_IDX_PHASE, 1'b1, 32'h0004);
        bus(`PRTC_IDX_CTRL, 1'b1, 32'h0008);
        bus(`PRTC_IDX_NS_LO, 1'b1, 32'h0000);
        bus(`PRTC_IDX_CTRL, 1'b1, 32'h0010);
        ticks(3);
        chk("loaded", 32'h00015a5a, {2'b00, rtc_nanoseconds});
        chk("load_phase", 32'h4, {29'h0, rtc_sub_phase});
        rd_chk("sample", `PRTC_IDX_NS_LO, 16'h5a5a);
        rd_chk("sample_phase", `PRTC_IDX_PHASE, 16'h0004);
        bus(`PRTC_IDX_RATE_HI, 1'b1, 32'h4000);
        ticks(3);
        chk("temp_zero", 32'h0, {31'h0, rtc_temp_adjust});
        bus(`PRTC_IDX_RATE_LO, 1'b1, 32'h0001);
        bus(`PRTC_IDX_RATE_HI, 1'b1, 32'h4000);
        ticks(1);
        chk("temp_set", 32'h1, {31'h0, rtc_temp_adjust});
        temp_adjust_done <= 1'b1;
        ticks(1);
        temp_adjust_done <= 1'b0;
        ticks(3);
        chk("temp_done", 32'h0, {31'h0, rtc_temp_adjust});
        end_sim();
    end
endmodule
